// ==== verilog/relay_port_pkg.sv ====
// package for the isolated input / relay output port
// shared by the port top and its per-input filter
package relay_port_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int FILTER_MS = 5;
  localparam int FILTER_CYCLES = (CLK_HZ / 1000) * FILTER_MS;
  localparam int CH_COUNT = 16;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFS_RELAY_LO = 3'h0;
  localparam logic [2:0] OFS_INPUT_LO = 3'h1;
  localparam logic [2:0] OFS_IRQ_CTRL = 3'h2;
  localparam logic [2:0] OFS_FILT_CTRL = 3'h3;
  localparam logic [2:0] OFS_RELAY_HI = 3'h4;
  localparam logic [2:0] OFS_INPUT_HI = 3'h5;
  localparam logic [2:0] OFS_IRQ_STAT = 3'h6;
  localparam logic [2:0] OFS_FILT_STAT = 3'h7;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam int STAT_EN0_BIT = 0;
  localparam int STAT_EN1_BIT = 1;
  localparam int STAT_PEND_BIT = 2;
  localparam logic [15:0] RELAY_RESET = 16'h0000;
  typedef enum logic [1:0] {
    IN_MODE_DC = 2'b00,
    IN_MODE_AC = 2'b01
  } in_mode_t;
endpackage

// ==== verilog/input_filter.sv ====
// one input channel: two-flop synchroniser and optional debounce filter
// assumes clk_sys domain; raw input may be asynchronous
`timescale 1ns/1ns
module input_filter
  import relay_port_pkg::*;
#(
  parameter int COUNT = FILTER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic raw_in,
  input wire logic filter_on,
  output logic level_out
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(COUNT - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic sync_a;
  logic sync_b;
  logic [CW-1:0] count;
  logic held;
  wire differs = sync_b != held;
  wire settled = differs && (count == CNT_LAST);
  wire next_held = filter_on ? (settled ? sync_b : held) : sync_b;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else if (ce) begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // level must stand a full filter time before it is accepted
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= CNT_ZERO;
      held <= 1'b0;
    end else if (ce) begin
      held <= next_held;
      if (!filter_on || !differs || settled) begin
        count <= CNT_ZERO;
      end else begin
        count <= count + CNT_ONE;
      end
    end
  end

  assign level_out = held;
endmodule // input_filter

// ==== verilog/relay_port.sv ====
// isolated input / relay output port with change interrupt
// assumes one-cycle read/write strobes from the host bus bridge
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns

module relay_port
  import relay_port_pkg::*;
#(
  parameter int CHANNELS = CH_COUNT,
  parameter int FILTER_COUNT = FILTER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic [CHANNELS-1:0] iso_in,
  input wire logic ac_mode,
  output logic [CHANNELS-1:0] relay_out,
  output logic irq
);
  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire wr_relay_lo = wr && (addr == OFS_RELAY_LO);
  wire wr_relay_hi = wr && (addr == OFS_RELAY_HI);
  wire wr_irq_clear = wr && (addr == OFS_INPUT_LO);
  wire wr_irq_off = wr && (addr == OFS_IRQ_CTRL);
  wire rd_irq_on = rd && (addr == OFS_IRQ_CTRL);
  wire wr_filt_off = wr && (addr == OFS_FILT_CTRL);
  wire rd_filt_on = rd && (addr == OFS_FILT_CTRL);

  // ------------------------------------------------------------
  // input channels
  // ------------------------------------------------------------
  logic filter_on;
  logic [CHANNELS-1:0] in_level;

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_in
      input_filter #(
        .COUNT(FILTER_COUNT)
      ) u_filt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .raw_in(iso_in[gi]),
        .filter_on(filter_on),
        .level_out(in_level[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // filter control
  // ------------------------------------------------------------
  // a read of OFS_FILT_CTRL turns the filters on; a write to it turns them off
  wire next_filter_on = rd_filt_on ? 1'b1 : (wr_filt_off ? 1'b0 : filter_on);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filter_on <= 1'b0;
    end else if (ce) begin
      filter_on <= next_filter_on;
    end
  end

  // ------------------------------------------------------------
  // change detection and interrupt
  // ------------------------------------------------------------
  logic [CHANNELS-1:0] prev_level;
  logic prev_valid;
  logic irq_en;
  logic irq_pend;

  wire [CHANNELS-1:0] rise_fall = in_level ^ prev_level;
  wire [CHANNELS-1:0] drop = prev_level & ~in_level;
  wire [CHANNELS-1:0] changed = ac_mode ? drop : rise_fall;
  // first sample after reset only primes the history
  wire change_evt = prev_valid && (|changed);
  wire next_irq_en = rd_irq_on ? 1'b1 : (wr_irq_off ? 1'b0 : irq_en);
  // with irq_en set, a change in the clear cycle wins, so no event is lost
  wire next_irq_pend = (irq_en && change_evt) ? 1'b1 :
                       (wr_irq_clear ? 1'b0 : irq_pend);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_level <= '0;
      prev_valid <= 1'b0;
    end else if (ce) begin
      prev_level <= in_level;
      prev_valid <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= 1'b0;
      irq_pend <= 1'b0;
    end else if (ce) begin
      irq_en <= next_irq_en;
      irq_pend <= next_irq_pend;
    end
  end

  // disabling masks the line but keeps the pending bit
  assign irq = irq_pend && irq_en;

  // ------------------------------------------------------------
  // relay latches
  // ------------------------------------------------------------
  logic [CHANNELS-1:0] relay;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      relay <= RELAY_RESET;
    end else if (ce) begin
      if (wr_relay_lo) begin
        relay[7:0] <= wdata;
      end
      if (wr_relay_hi) begin
        relay[15:8] <= wdata;
      end
    end
  end

  assign relay_out = relay;

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  wire [DATA_W-1:0] irq_stat = {5'b00000, irq_pend, irq_en, irq_en};
  wire [DATA_W-1:0] filt_stat = filter_on ? BYTE_ONES : BYTE_ZERO;
  logic [DATA_W-1:0] read_mux;

  always_comb begin
    unique case (addr)
      OFS_RELAY_LO: read_mux = relay[7:0];
      OFS_INPUT_LO: read_mux = in_level[7:0];
      OFS_IRQ_CTRL: read_mux = BYTE_ZERO;
      OFS_FILT_CTRL: read_mux = BYTE_ZERO;
      OFS_RELAY_HI: read_mux = relay[15:8];
      OFS_INPUT_HI: read_mux = in_level[15:8];
      OFS_IRQ_STAT: read_mux = irq_stat;
      OFS_FILT_STAT: read_mux = filt_stat;
    endcase
  end

  // all eight offsets decode; data valid the cycle after rd
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= BYTE_ZERO;
    end else if (ce) begin
      rdata <= rd ? read_mux : BYTE_ZERO;
    end
  end
endmodule // relay_port

// ==== testbench/relay_port_checker.sv ====
// checker for relay_port bus, relays and interrupt
// assumes bound to relay_port with its own parameters
`timescale 1ns/1ns
module relay_port_checker
  import relay_port_pkg::*;
#(
  parameter int CHANNELS = CH_COUNT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [CHANNELS-1:0] relay_out,
  input wire logic irq
);
  // ----
  // properties
  // ----
  wire logic wr_ok;
  wire logic rd_ok;
  assign wr_ok = wr && ce;
  assign rd_ok = rd && ce;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_lo;
    wr_ok && addr == OFS_RELAY_LO |=> relay_out[7:0] == $past(wdata);
  endproperty
  a_lo: assert property (p_lo) else $error("relay lo");
  property p_hi;
    wr_ok && addr == OFS_RELAY_HI |=> relay_out[15:8] == $past(wdata);
  endproperty
  a_hi: assert property (p_hi) else $error("relay hi");
  property p_hold;
    !(wr_ok && addr[1:0] == 2'h0) |=> $stable(relay_out);
  endproperty
  a_hold: assert property (p_hold) else $error("relay moved");
  property p_dis;
    wr_ok && addr == OFS_IRQ_CTRL |=> !irq;
  endproperty
  a_dis: assert property (p_dis) else $error("irq on");
  property p_stat;
    rd_ok && addr == OFS_IRQ_STAT && irq |=> rdata == 8'h07;
  endproperty
  a_stat: assert property (p_stat) else $error("status");
  property p_filt;
    rd_ok && addr == OFS_FILT_STAT |=> rdata == 8'hFF || rdata == 8'h00;
  endproperty
  a_filt: assert property (p_filt) else $error("filter stat");
  property p_latch;
    irq && !(wr_ok && (addr == OFS_INPUT_LO || addr == OFS_IRQ_CTRL))
      |=> irq;
  endproperty
  a_latch: assert property (p_latch) else $error("irq lost");
  property p_rst;
    $rose(rst_n) |-> !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("irq at reset");
  c_irq: cover property (!irq ##1 irq);
  c_filt: cover property (rd_ok && addr == OFS_FILT_STAT ##1 rdata[0]);
  c_clr: cover property (irq ##1 !irq);
endmodule // relay_port_checker
bind relay_port relay_port_checker #(.CHANNELS(CHANNELS)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .relay_out(relay_out), .irq(irq));

// ==== testbench/host_bus.sv ====
// host model: one-cycle read and write strobes on the register port
// assumes rdata stands only in the cycle after rd
`timescale 1ns/1ns
module host_bus (
  input wire logic clk_sys,
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial {addr, wdata, wr, rd} = 13'h0000;
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clk_sys);
    // released data shows garbage, not the last byte
    {wdata, wr} <= {~v, 1'b0};
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
  endtask
endmodule // host_bus

// ==== testbench/relay_port_tb.sv ====
// bench for relay_port: relays, inputs, interrupt, filter
// assumes host_bus drives the register port
`timescale 1ns/1ns
module relay_port_tb
  import relay_port_pkg::*;
  ;
  logic clk_sys, rst_n, ac_mode, irq, wr, rd;
  logic ce = 1'b1;
  logic [15:0] iso_in, relay_out;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, s, d;
  int err_total = 0, num_checks = 0, cyc = 0;
  relay_port #(.FILTER_COUNT(8)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .iso_in(iso_in), .ac_mode(ac_mode), .relay_out(relay_out), .irq(irq));
  host_bus i_host (.clk_sys(clk_sys), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [7:0] stat(input logic en, input logic p);
    return {5'h00, p, en, en};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %h %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.rd_reg(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic ic(input logic e);
    @(negedge clk_sys);
    chk({15'h0000, irq}, {15'h0000, e});
  endtask
  task automatic put(input logic [15:0] v, input int n);
    @(posedge clk_sys) iso_in <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic results();
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    {rst_n, ac_mode, iso_in, s} = {18'h00000, 8'h40};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rc(OFS_RELAY_HI, 8'h00);
    rc(OFS_IRQ_STAT, stat(1'b0, 1'b0));
    rc(OFS_FILT_STAT, BYTE_ZERO);
    // clock enable low must freeze the relay latch
    @(posedge clk_sys) ce <= 1'b0;
    i_host.wr_reg(OFS_RELAY_LO, 8'h5A);
    chk(relay_out, RELAY_RESET);
    @(posedge clk_sys) ce <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      s = lfsr(s);
      d = lfsr(s);
      i_host.wr_reg(OFS_RELAY_LO, s);
      i_host.wr_reg(OFS_RELAY_HI, d);
      i_host.wr_reg(OFS_IRQ_STAT, ~s);
      chk(relay_out, {d, s});
      rc(OFS_RELAY_LO, s);
      put({s, d}, 6);
      rc(OFS_INPUT_LO, d);
      rc(OFS_INPUT_HI, s);
      ic(1'b0);
    end
    put(16'h0000, 6);
    i_host.rd_reg(OFS_IRQ_CTRL, d);
    rc(OFS_IRQ_STAT, stat(1'b1, 1'b0));
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys) ac_mode <= m[0];
      put(16'h0001, 6);
      ic(m == 0);
      i_host.wr_reg(OFS_INPUT_LO, s);
      ic(1'b0);
      put(16'h0000, 6);
      ic(1'b1);
      rc(OFS_IRQ_STAT, stat(1'b1, 1'b1));
      put(16'h0001, 6);
      ic(1'b1);
      i_host.wr_reg(OFS_INPUT_LO, s);
    end
    i_host.wr_reg(OFS_IRQ_CTRL, s);
    rc(OFS_IRQ_STAT, stat(1'b0, 1'b0));
    i_host.rd_reg(OFS_FILT_CTRL, d);
    rc(OFS_FILT_STAT, BYTE_ONES);
    // short pulse must be swallowed, long level accepted
    put(16'h0101, 3);
    put(16'h0001, 20);
    rc(OFS_INPUT_HI, 8'h00);
    put(16'h0101, 20);
    rc(OFS_INPUT_HI, 8'h01);
    i_host.wr_reg(OFS_FILT_CTRL, s);
    rc(OFS_FILT_STAT, BYTE_ZERO);
    results();
  end
endmodule // relay_port_tb
